// *** verilog/jtag_tap_pkg.sv ***
// Purpose: Shared constants and types for the boundary-scan test access port.
// Assumes: One six-bit instruction register and a short boundary cell chain.
// Notes: Instruction codes and chain length are local choices of this design.

package jtag_tap_pkg;

	// ----------------------------------------------------------------
	// Controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		ST_RESET = 4'b0000,
		ST_IDLE = 4'b0001,
		ST_SEL_DR = 4'b0010,
		ST_CAP_DR = 4'b0011,
		ST_SH_DR = 4'b0100,
		ST_EX1_DR = 4'b0101,
		ST_PAU_DR = 4'b0110,
		ST_EX2_DR = 4'b0111,
		ST_UPD_DR = 4'b1000,
		ST_SEL_IR = 4'b1001,
		ST_CAP_IR = 4'b1010,
		ST_SH_IR = 4'b1011,
		ST_EX1_IR = 4'b1100,
		ST_PAU_IR = 4'b1101,
		ST_EX2_IR = 4'b1110,
		ST_UPD_IR = 4'b1111
	} tap_state_e;

	// ----------------------------------------------------------------
	// Scan path selection
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PATH_BYPASS = 2'b00,
		PATH_ID = 2'b01,
		PATH_CHAIN = 2'b10
	} dr_path_e;

	// Widths of the instruction register, id register and cell chain.
	localparam int IR_W = 6;
	localparam int ID_W = 32;
	localparam int CHAIN_LEN = 8;

	// Instruction codes; all ones is bypass, unknown codes also bypass.
	localparam logic [IR_W-1:0] INS_EXTEST = 6'h00;
	localparam logic [IR_W-1:0] INS_SAMPLE = 6'h01;
	localparam logic [IR_W-1:0] INS_IDCODE = 6'h02;
	localparam logic [IR_W-1:0] INS_BYPASS = 6'h3f;

	// Pattern loaded at capture-IR; the two low bits are fixed at 01.
	localparam logic [IR_W-1:0] IR_CAPTURE = 6'h01;
	// Instruction held after any reset.
	localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;

	// Maps an instruction onto the data register it places in the path.
	function automatic dr_path_e path_of(input logic [IR_W-1:0] ins);
		dr_path_e p;
		p = PATH_BYPASS;
		case (ins)
			INS_EXTEST, INS_SAMPLE: p = PATH_CHAIN;
			INS_IDCODE: p = PATH_ID;
			default: p = PATH_BYPASS;
		endcase
		return p;
	endfunction : path_of

endpackage : jtag_tap_pkg

// *** verilog/tap_fsm.sv ***
// Purpose: Sixteen-state test access port controller.
// Assumes: Mode select is synchronous to the test clock.
// Notes: Reset is asynchronous on the active-low test reset pin.

`timescale 1ns/1ps

module tap_fsm
	import jtag_tap_pkg::*;
(
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tms,
	output tap_state_e state_q
);

	tap_state_e state_d;

	// ----------------------------------------------------------------
	// Next state from the mode select level
	// ----------------------------------------------------------------
	// Every state moves toward reset on a one, so five ones always land in reset.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_RESET: state_d = tms ? ST_RESET : ST_IDLE;
			ST_IDLE: state_d = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_d = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: state_d = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: state_d = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: state_d = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_d = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: state_d = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: state_d = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_IDLE;
			default: state_d = ST_RESET;
		endcase
	end

	// State register; the pin reset needs no clock edge.
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			state_q <= ST_RESET;
		else
			state_q <= state_d;
	end

	// Five ones on mode select reach reset from anywhere.
	chk_five_ones_reset: assert property (@(posedge tck) disable iff (!trst_n)
		tms [*5] |=> state_q == ST_RESET)
		else $error("five ones on mode select did not reach reset");

	// Select-DR with a one goes to select-IR.
	chk_sel_dr_step: assert property (@(posedge tck) disable iff (!trst_n)
		(state_q == ST_SEL_DR && tms) |=> state_q == ST_SEL_IR)
		else $error("select-DR did not step to select-IR");

	// Idle with a zero stays idle, with a one leaves for select-DR.
	chk_idle_step: assert property (@(posedge tck) disable iff (!trst_n)
		state_q == ST_IDLE |=> state_q == ($past(tms) ? ST_SEL_DR : ST_IDLE))
		else $error("idle state stepped wrongly");

endmodule : tap_fsm

// *** verilog/jtag_tap_controller.sv ***
// Purpose: Boundary-scan test access port with instruction and data registers.
// Assumes: Scan logic runs on the test clock; core logic on core_clk.
// Notes: Updates toward the core cross by a toggle and a two-flop synchroniser.
//
// What this block does
// - A sixteen-state controller sequences every scan operation.
// - A six-bit instruction register selects the test and the data register in the path.
// - The port uses five pins: test clock, mode select, data in, data out and test reset.
// - The active-low test reset puts the controller in reset without a clock edge.
// - Mode select and data in are sampled on the rising test-clock edge.
// - Data out changes on the falling test-clock edge.
// - Data out is driven only in shift-DR and shift-IR and floats otherwise.
// - The controller steps on the mode select level along the standard state graph.
// - Five rising edges with mode select high reach reset from any state.
// - Data in feeds the cell chain, instruction, id or bypass register as selected.
// - An id register can be read through the scan port.
// - Only the DC-coupled pin test is provided, with no AC-coupled test mode.
// - A shifted instruction takes effect only in update-IR.
// - The cell chain sits in the path only under the external-test or sample instruction.

`timescale 1ns/1ps

module jtag_tap_controller
	import jtag_tap_pkg::*;
#(
	// Id register contents; the value is arbitrary, bit 0 must stay one.
	parameter logic [ID_W-1:0] ID_VALUE = 32'h0a5a_c001
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [CHAIN_LEN-1:0] pin_sense,
	output logic [CHAIN_LEN-1:0] pin_drive,
	output logic pin_test_en
);

	// ----------------------------------------------------------------
	// Controller
	// ----------------------------------------------------------------
	tap_state_e state_q;
	logic [IR_W-1:0] ir_sh_q;
	logic [IR_W-1:0] ir_q;
	logic bypass_q;
	logic [ID_W-1:0] id_sh_q;
	logic [CHAIN_LEN-1:0] chain_sh_q;
	logic [CHAIN_LEN-1:0] chain_upd_q;
	logic [CHAIN_LEN-1:0] sense_s1_q;
	logic [CHAIN_LEN-1:0] sense_s2_q;
	logic upd_tgl_q;
	logic tdo_q;
	logic tdo_oe_q;
	logic tgl_s1_q;
	logic tgl_s2_q;
	logic tgl_s3_q;
	logic [CHAIN_LEN-1:0] pin_drive_q;
	logic pin_test_en_q;
	dr_path_e path;

	// Mode select and data in are used raw on the rising test-clock edge:
	// they are launched by the tester against this same clock. The pad
	// pull-ups leave undriven pins at one, which walks the controller
	// to reset and loads ones, a harmless idle pattern.
	tap_fsm u_fsm
	(
		.tck(tck),
		.trst_n(trst_n),
		.tms(tms),
		.state_q(state_q)
	);

	// The active instruction picks the data register in the path.
	assign path = path_of(ir_q);

	// ----------------------------------------------------------------
	// Instruction register
	// ----------------------------------------------------------------
	// Shift stage: captures the fixed pattern, then shifts LSB first.
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			ir_sh_q <= IR_CAPTURE;
		else if (state_q == ST_CAP_IR)
			ir_sh_q <= IR_CAPTURE;
		else if (state_q == ST_SH_IR)
			ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
	end

	// Active instruction: changes only in update-IR or reset, so a half-shifted
	// value never disturbs the pins under test.
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			ir_q <= IR_RESET;
		else if (state_q == ST_RESET)
			ir_q <= IR_RESET;
		else if (state_q == ST_UPD_IR)
			ir_q <= ir_sh_q;
	end

	// ----------------------------------------------------------------
	// Data registers
	// ----------------------------------------------------------------
	// Bypass: one cell, cleared at capture.
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			bypass_q <= 1'b0;
		else if (path == PATH_BYPASS && state_q == ST_CAP_DR)
			bypass_q <= 1'b0;
		else if (path == PATH_BYPASS && state_q == ST_SH_DR)
			bypass_q <= tdi;
	end

	// Id register: loads the part code at capture, then shifts out.
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			id_sh_q <= ID_VALUE;
		else if (path == PATH_ID && state_q == ST_CAP_DR)
			id_sh_q <= ID_VALUE;
		else if (path == PATH_ID && state_q == ST_SH_DR)
			id_sh_q <= {tdi, id_sh_q[ID_W-1:1]};
	end

	// Pin levels come from outside the test clock, so two flops first.
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			sense_s1_q <= '0;
			sense_s2_q <= '0;
		end
		else
		begin
			sense_s1_q <= pin_sense;
			sense_s2_q <= sense_s1_q;
		end
	end

	// Cell chain: only static pin levels are observed, since the pins
	// carry DC-coupled signals; no AC-coupled test waveform is produced.
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			chain_sh_q <= '0;
		else if (path == PATH_CHAIN && state_q == ST_CAP_DR)
			chain_sh_q <= sense_s2_q;
		else if (path == PATH_CHAIN && state_q == ST_SH_DR)
			chain_sh_q <= {tdi, chain_sh_q[CHAIN_LEN-1:1]};
	end

	// Update latches of the chain, loaded only while the chain is in the path.
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			chain_upd_q <= '0;
		else if (path == PATH_CHAIN && state_q == ST_UPD_DR)
			chain_upd_q <= chain_sh_q;
	end

	// ----------------------------------------------------------------
	// Serial output on the falling edge
	// ----------------------------------------------------------------
	// Driving on the falling edge gives the tester half a period of setup
	// before its own rising-edge sample.
	always_ff @(negedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			tdo_q <= 1'b1;
			tdo_oe_q <= 1'b0;
		end
		else
		begin
			tdo_oe_q <= (state_q == ST_SH_DR) || (state_q == ST_SH_IR);
			if (state_q == ST_SH_IR)
				tdo_q <= ir_sh_q[0];
			else if (path == PATH_CHAIN)
				tdo_q <= chain_sh_q[0];
			else if (path == PATH_ID)
				tdo_q <= id_sh_q[0];
			else
				tdo_q <= bypass_q;
		end
	end

	assign tdo = tdo_q;
	assign tdo_oe = tdo_oe_q;

	// ----------------------------------------------------------------
	// Crossing toward the core clock
	// ----------------------------------------------------------------
	// One toggle per update-IR or chain update-DR; the words it announces stay still until the
	// next update, which must be far enough away for the core to copy them.
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			upd_tgl_q <= 1'b0;
		else if (state_q == ST_UPD_IR || (path == PATH_CHAIN && state_q == ST_UPD_DR))
			upd_tgl_q <= ~upd_tgl_q;
	end

	// Toggle synchroniser; only the second and third stages are compared.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end
		else
		begin
			tgl_s1_q <= upd_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	// Core copies of the drive values and the external-test mode.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_drive_q <= '0;
			pin_test_en_q <= 1'b0;
		end
		else if (tgl_s2_q != tgl_s3_q)
		begin
			pin_drive_q <= chain_upd_q;
			pin_test_en_q <= (ir_q == INS_EXTEST);
		end
	end

	assign pin_drive = pin_drive_q;
	assign pin_test_en = pin_test_en_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_tdo_float_rule: assert property (@(posedge tck) disable iff (!trst_n)
		tdo_oe_q == (state_q == ST_SH_DR || state_q == ST_SH_IR))
		else $error("data out enable does not follow the shift states");

	chk_tdo_ir_bit: assert property (@(posedge tck) disable iff (!trst_n)
		state_q == ST_SH_IR |-> tdo_q == ir_sh_q[0])
		else $error("data out does not carry the instruction bit");

	chk_ir_update_load: assert property (@(posedge tck) disable iff (!trst_n)
		state_q == ST_UPD_IR |=> ir_q == $past(ir_sh_q))
		else $error("instruction not taken in update-IR");

	chk_ir_hold_value: assert property (@(posedge tck) disable iff (!trst_n)
		(state_q != ST_UPD_IR && state_q != ST_RESET) |=> $stable(ir_q))
		else $error("instruction changed outside update-IR");

	chk_reset_id_path: assert property (@(posedge tck) disable iff (!trst_n)
		state_q == ST_RESET |=> path == PATH_ID)
		else $error("id path not selected after reset");

	chk_bypass_shift: assert property (@(posedge tck) disable iff (!trst_n)
		(path == PATH_BYPASS && state_q == ST_SH_DR) |=> bypass_q == $past(tdi))
		else $error("bypass cell did not take data in");

	chk_chain_isolated: assert property (@(posedge tck) disable iff (!trst_n)
		(path != PATH_CHAIN && state_q == ST_SH_DR) |=> $stable(chain_sh_q))
		else $error("cell chain shifted while not selected");

	chk_id_capture_code: assert property (@(posedge tck) disable iff (!trst_n)
		(path == PATH_ID && state_q == ST_CAP_DR) |=> id_sh_q == ID_VALUE)
		else $error("id register did not load the part code");

	chk_ir_shift_bits: assert property (@(posedge tck) disable iff (!trst_n)
		state_q == ST_SH_IR |=> ir_sh_q[IR_W-1] == $past(tdi))
		else $error("instruction shift did not enter at the top bit");

	// Capture values of the bypass cell and the cell chain, and the id bit on data out.
	chk_bypass_capture: assert property (@(posedge tck) disable iff (!trst_n)
		(path == PATH_BYPASS && state_q == ST_CAP_DR) |=> bypass_q == 1'b0)
		else $error("bypass cell did not capture zero");

	chk_chain_capture: assert property (@(posedge tck) disable iff (!trst_n)
		(path == PATH_CHAIN && state_q == ST_CAP_DR) |=> chain_sh_q == $past(sense_s2_q))
		else $error("cell chain did not capture the pin levels");

	chk_tdo_id_bit: assert property (@(posedge tck) disable iff (!trst_n)
		(path == PATH_ID && state_q == ST_SH_DR) |-> tdo_q == id_sh_q[0])
		else $error("data out does not carry the id bit");

	chk_core_copy_delay: assert property (@(posedge core_clk) disable iff (!arst_n)
		$changed(tgl_s2_q) |=> pin_drive_q == $past(chain_upd_q))
		else $error("core copy of drive values missed");

endmodule : jtag_tap_controller

// *** bench/jtag_tester.sv ***
// Purpose: Board tester model that drives four test access port pins and reads data out.
// Assumes: The test clock runs only inside frames, at a 32 ns period.
// Notes: Released lines read one, as the pull-ups would leave them.

`timescale 1ns/1ps

module jtag_tester
(
	output logic tck,
	output logic trst_n,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// The clock stands still low between frames; reset is held at power-up.
	initial
	begin
		tck = 1'b0;
		trst_n = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One clock cycle: set up after the fall, sample data out at the rise.
	// The lines move 1 ns after the fall, so a release and the next setup
	// never fall in one time step.
	task automatic step(input logic m, input logic d, output logic o, output logic oe);
		#1 tms = m;
		tdi = d;
		#15 tck = 1'b1;
		// Data out has no pull, so a floating line reads inverted to expose stale bits.
		o = tdo_oe ? tdo : ~tdo;
		oe = tdo_oe;
		#16 tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	endtask : step

	// The reset pin moves while the clock is still, so nothing else helps.
	task automatic set_trst(input logic v);
		trst_n = v;
	endtask : set_trst

	// Five cycles with mode select high reach reset from any state.
	task automatic tms_reset();
		logic o;
		logic oe;
		repeat (5) step(1'b1, 1'b1, o, oe);
	endtask : tms_reset
endmodule : jtag_tester

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the test access port.
// Assumes: The tester model makes the test clock only inside frames.
// Notes: Each scenario task drives the port and judges its answers.

`timescale 1ns/1ps

module tb
	import jtag_tap_pkg::*;
;
	// Id value for this bench; arbitrary, bit 0 kept one.
	localparam logic [ID_W-1:0] ID_EXP = 32'h1234_5671;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [CHAIN_LEN-1:0] pin_sense = 8'h00;
	logic tdo_rise;
	wire logic tck;
	wire logic trst_n;
	wire logic tms;
	wire logic tdi;
	wire logic tdo;
	wire logic tdo_oe;
	wire logic [CHAIN_LEN-1:0] pin_drive;
	wire logic pin_test_en;
	int n_fail = 0;
	int n_checks = 0;

	// ----------------------------------------------------------------
	// Clock and instances
	// ----------------------------------------------------------------
	always #20 core_clk = ~core_clk;

	jtag_tap_controller #(.ID_VALUE(ID_EXP)) dut (.core_clk(core_clk), .arst_n(arst_n),
		.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.pin_sense(pin_sense), .pin_drive(pin_drive), .pin_test_en(pin_test_en));

	jtag_tester u_tester (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	// Scan from idle; hold parks in a pause state instead of updating.
	task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic hold,
		output logic [31:0] dout);
		logic o;
		logic oe;
		logic all_oe;
		all_oe = 1'b1;
		dout = '0;
		u_tester.step(1'b1, 1'b1, o, oe);
		if (ir)
			u_tester.step(1'b1, 1'b1, o, oe);
		u_tester.step(1'b0, 1'b1, o, oe);
		u_tester.step(1'b0, 1'b1, o, oe);
		for (int i = 0; i < n; i++)
		begin
			u_tester.step(i == n - 1, din[i], o, oe);
			dout[i] = o;
			all_oe = all_oe & oe;
		end
		chk(all_oe === 1'b1, "data out floats while shifting");
		u_tester.step(!hold, 1'b1, o, oe);
		chk(oe === 1'b0, "data out driven after shift");
		if (!hold)
			u_tester.step(1'b0, 1'b1, o, oe);
	endtask : scan

	// Leaves a pause state through update back to idle.
	task automatic end_pause();
		logic o;
		logic oe;
		u_tester.step(1'b1, 1'b1, o, oe);
		u_tester.step(1'b1, 1'b1, o, oe);
		u_tester.step(1'b0, 1'b1, o, oe);
	endtask : end_pause

	task automatic load_ir(input logic [IR_W-1:0] code, input logic hold);
		logic [31:0] d;
		scan(1'b1, IR_W, {26'h0, code}, hold, d);
		chk(d[IR_W-1:0] === IR_CAPTURE, "instruction capture");
	endtask : load_ir

	task automatic read_id();
		logic [31:0] d;
		scan(1'b0, ID_W, 32'h0, 1'b0, d);
		chk(d === ID_EXP, "id register");
	endtask : read_id

	// The core copy lags the test clock, so poll for a bounded time.
	task automatic wait_drive(input logic [CHAIN_LEN-1:0] pd, input logic te);
		int k;
		k = 0;
		while (k < 20 && !(pin_drive === pd && pin_test_en === te))
		begin
			@(negedge core_clk);
			k++;
		end
		chk(pin_drive === pd && pin_test_en === te, "core copy");
		// A copy that never arrives ends the run with the report.
		if (!(pin_drive === pd && pin_test_en === te))
			finish_test();
	endtask : wait_drive

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	// Data out may move only on the falling test-clock edge.
	always @(posedge tck)
	begin
		tdo_rise = tdo;
		#2;
		if (trst_n === 1'b1)
			chk(tdo === tdo_rise, "data out moved at rise");
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Id after reset, then the reset pin alone must silence a shifting port.
	task automatic t_reset_id();
		logic o;
		logic oe;
		u_tester.step(1'b0, 1'b1, o, oe);
		read_id();
		u_tester.step(1'b1, 1'b1, o, oe);
		u_tester.step(1'b0, 1'b1, o, oe);
		u_tester.step(1'b0, 1'b1, o, oe);
		// Let the falling-edge flops settle before looking.
		#2;
		chk(tdo_oe === 1'b1, "shift not driving");
		u_tester.set_trst(1'b0);
		#5;
		chk(tdo_oe === 1'b0, "reset pin ignored");
		u_tester.set_trst(1'b1);
		u_tester.step(1'b0, 1'b1, o, oe);
		read_id();
		$display("test reset_id done");
	endtask : t_reset_id

	// Bypass and an unknown code both give a one-bit path that captured 0.
	task automatic t_bypass();
		logic [31:0] d;
		logic [IR_W-1:0] codes [2];
		codes = '{INS_BYPASS, 6'h15};
		foreach (codes[j])
		begin
			load_ir(codes[j], 1'b0);
			scan(1'b0, 9, 32'h0000_00a5, 1'b0, d);
			chk(d[8:0] === {8'ha5, 1'b0}, "bypass path");
		end
		$display("test bypass done");
	endtask : t_bypass

	// Sample captures the pins; external test goes live only after update-IR.
	task automatic t_chain();
		logic [31:0] d;
		@(negedge core_clk);
		pin_sense = 8'h3c;
		load_ir(INS_SAMPLE, 1'b0);
		scan(1'b0, CHAIN_LEN, 32'h96, 1'b0, d);
		chk(d[7:0] === 8'h3c, "sample capture");
		wait_drive(8'h96, 1'b0);
		@(negedge core_clk);
		pin_sense = 8'hc3;
		load_ir(INS_EXTEST, 1'b1);
		repeat (10) @(negedge core_clk);
		chk(pin_test_en === 1'b0, "instruction live before update");
		end_pause();
		wait_drive(8'h96, 1'b1);
		scan(1'b0, CHAIN_LEN, 32'h5a, 1'b1, d);
		chk(d[7:0] === 8'hc3, "external test capture");
		repeat (6) @(negedge core_clk);
		chk(pin_drive === 8'h96, "drive values moved before update-DR");
		end_pause();
		wait_drive(8'h5a, 1'b1);
		load_ir(INS_IDCODE, 1'b0);
		read_id();
		wait_drive(8'h5a, 1'b0);
		$display("test chain done");
	endtask : t_chain

	// Five mode-select ones in mid-shift restore the id instruction.
	task automatic t_tms_reset();
		logic o;
		logic oe;
		load_ir(INS_BYPASS, 1'b0);
		u_tester.step(1'b1, 1'b1, o, oe);
		u_tester.step(1'b1, 1'b1, o, oe);
		u_tester.step(1'b0, 1'b1, o, oe);
		u_tester.step(1'b0, 1'b0, o, oe);
		u_tester.step(1'b0, 1'b0, o, oe);
		u_tester.tms_reset();
		#2;
		chk(tdo_oe === 1'b0, "driving after mode reset");
		u_tester.step(1'b0, 1'b1, o, oe);
		read_id();
		$display("test tms_reset done");
	endtask : t_tms_reset

	// Main sequence: both resets held for eight core cycles first.
	initial
	begin
		u_tester.set_trst(1'b0);
		repeat (8) @(negedge core_clk);
		arst_n = 1'b1;
		u_tester.set_trst(1'b1);
		wait_drive(8'h00, 1'b0);
		t_reset_id();
		t_bypass();
		t_chain();
		t_tms_reset();
		finish_test();
	end
endmodule : tb
